//--- inc/speed_torque_regs.vh
// Contract
// [RULE_01] Internal speed limit in RPM, settable 1 to 5000, resets to 5000.
// [RULE_02] Speed reference is clamped so the motor never exceeds the active limit.
// [RULE_03] Speed-limit-reached flag is raised while motor speed is at the active limit.
// [RULE_04] Reached flag drives an output only when mapped to a sequence output channel.
// [RULE_05] Source selector picks internal limit setting or host-supplied limit command.
// [RULE_06] With host source selected, the internal limit value has no effect at all.
// [RULE_07] Torque reference percent equals input volts times gain, 0.0 to 100.0, default 33.3.
// [RULE_08] Gain changes are accepted only while the servo output is disabled.
// [RULE_09] Host keeps the analog torque command between minus and plus ten volts.
// [RULE_10] Over-range warning when scaled torque command exceeds configured motor maximum torque.
// [RULE_11] Torque command is one analog value on a signal line and its ground.
// [RULE_12] Torque command is converted to a signed word, sampled at fixed loop rate.
`ifndef SPEED_TORQUE_REGS_VH
`define SPEED_TORQUE_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_SPEED_LIMIT 8'h04
`define REG_TORQUE_GAIN 8'h08
`define REG_MAX_TORQUE  8'h0C
`define REG_STATE       8'h10
`define REG_IRQ_STATUS  8'h14
`define REG_IRQ_CLEAR   8'h18
`define REG_IRQ_ENABLE  8'h1C
`define REG_TORQUE_REF  8'h20
`define REG_SPEED_REF   8'h24

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define CTRL_SERVO_ON   0
`define CTRL_SRC_HOST   1
`define CTRL_CH_LO      2
`define CTRL_CH_HI      4
`define STATE_REACHED   0
`define STATE_OVERRANGE 1
`define IRQ_REACHED     0
`define IRQ_OVERRANGE   1

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define SPEED_LIMIT_MIN   13'h0001
`define SPEED_LIMIT_MAX   13'h1388
`define SPEED_LIMIT_RESET 13'h1388
`define GAIN_MAX          10'h03E8
`define GAIN_RESET        10'h014D
`define MAX_TORQUE_RESET  10'h012C

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS   100
`define LOOP_PERIOD_NS  100000
`define LOOP_CYCLES     (`LOOP_PERIOD_NS / `CLK_PERIOD_NS)

`endif

//--- verilog/torque_scaler.v
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Gain multiply: percent = code * gain(0.1 %/V) / 2048 for a +-10 V, 12-bit word.
// ----------------------------------------------------------------------------
module torque_scaler
(
	input  wire               pclk,
	input  wire               presetn,
	input  wire               start,
	input  wire signed [11:0] sample,
	input  wire        [9:0]  gain,
	output reg  signed [11:0] torque,
	output reg                done
);
	wire signed [22:0] product;

	assign product = sample * $signed({1'b0, gain});

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			torque <= 12'h000;
			done   <= 1'b0;
		end
		else
		begin
			done <= start;
			if (start)
				torque <= product[22:11]; // [RULE_07]
		end
	end
endmodule // torque_scaler

//--- verilog/speed_limit_torque_cmd_scaler.v
`timescale 1ns/1ps
`include "speed_torque_regs.vh"
module speed_limit_torque_cmd_scaler
#(
	parameter OUT_CHANNELS = 4,
	parameter LOOP_CYCLES  = `LOOP_CYCLES
)
(
	input  wire                    pclk,
	input  wire                    presetn,
	input  wire                    psel,
	input  wire                    penable,
	input  wire                    pwrite,
	input  wire [7:0]              paddr,
	input  wire [31:0]             pwdata,
	output reg  [31:0]             prdata,
	output reg                     pready,
	output reg                     pslverr,
	input  wire signed [15:0]      speed_cmd,
	input  wire signed [15:0]      motor_speed,
	input  wire [12:0]             host_speed_limit,
	input  wire [11:0]             torque_cmd_code,
	output reg  signed [15:0]      speed_ref,
	output reg  signed [11:0]      torque_ref,
	output reg                     speed_limit_reached,
	output reg                     torque_cmd_overrange_warn,
	output reg  [OUT_CHANNELS-1:0] seq_out,
	output reg                     irq
);
	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function [15:0] abs16;
		input signed [15:0] v;
		begin
			if (v == 16'h8000)
				abs16 = 16'h7FFF;
			else if (v < 0)
				abs16 = -v;
			else
				abs16 = v;
		end
	endfunction

	function is_mapped;
		input [7:0] a;
		begin
			case (a)
				`REG_CTRL, `REG_SPEED_LIMIT, `REG_TORQUE_GAIN, `REG_MAX_TORQUE,
				`REG_STATE, `REG_IRQ_STATUS, `REG_IRQ_CLEAR, `REG_IRQ_ENABLE,
				`REG_TORQUE_REF, `REG_SPEED_REF: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	reg        servo_on;
	reg        speed_limit_source_select;
	reg [2:0]  limit_channel;
	reg [12:0] speed_limit_value;
	reg [9:0]  torque_cmd_gain;
	reg [9:0]  max_torque;
	reg [1:0]  irq_status;
	reg [1:0]  irq_enable;

	wire access    = psel & penable;
	wire wr_commit = access & pready & pwrite;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			// One wait state gives the read mux a full cycle before pready.
			pready  <= access & ~pready;
			pslverr <= access & ~pready & ~is_mapped(paddr);
			if (access & ~pready & ~pwrite)
			begin
				case (paddr)
					`REG_CTRL:        prdata <= {27'h000_0000, limit_channel,
						speed_limit_source_select, servo_on};
					`REG_SPEED_LIMIT: prdata <= {19'h0_0000, speed_limit_value};
					`REG_TORQUE_GAIN: prdata <= {22'h00_0000, torque_cmd_gain};
					`REG_MAX_TORQUE:  prdata <= {22'h00_0000, max_torque};
					`REG_STATE:       prdata <= {30'h0000_0000,
						torque_cmd_overrange_warn, speed_limit_reached};
					`REG_IRQ_STATUS:  prdata <= {30'h0000_0000, irq_status};
					`REG_IRQ_ENABLE:  prdata <= {30'h0000_0000, irq_enable};
					`REG_TORQUE_REF:  prdata <= {{20{torque_ref[11]}}, torque_ref};
					`REG_SPEED_REF:   prdata <= {{16{speed_ref[15]}}, speed_ref};
					default:          prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			servo_on                  <= 1'b0;
			speed_limit_source_select <= 1'b0;
			limit_channel             <= 3'h0;
			speed_limit_value         <= `SPEED_LIMIT_RESET; // [RULE_01]
			torque_cmd_gain           <= `GAIN_RESET; // [RULE_07]
			max_torque                <= `MAX_TORQUE_RESET;
			irq_enable                <= 2'h0;
		end
		else if (wr_commit)
		begin
			case (paddr)
				`REG_CTRL:
				begin
					servo_on                  <= pwdata[`CTRL_SERVO_ON];
					speed_limit_source_select <= pwdata[`CTRL_SRC_HOST]; // [RULE_05]
					limit_channel             <= pwdata[`CTRL_CH_HI:`CTRL_CH_LO];
				end
				`REG_SPEED_LIMIT:
				begin
					// Out-of-range writes saturate to the nearest legal value.
					if (pwdata[31:0] < {19'h0_0000, `SPEED_LIMIT_MIN})
						speed_limit_value <= `SPEED_LIMIT_MIN; // [RULE_01]
					else if (pwdata[31:0] > {19'h0_0000, `SPEED_LIMIT_MAX})
						speed_limit_value <= `SPEED_LIMIT_MAX; // [RULE_01]
					else
						speed_limit_value <= pwdata[12:0];
				end
				`REG_TORQUE_GAIN:
				begin
					// A live gain step would jolt the motor, so writes are ignored while servo is on.
					if (!servo_on) // [RULE_08]
					begin
						if (pwdata[31:0] > {22'h00_0000, `GAIN_MAX})
							torque_cmd_gain <= `GAIN_MAX; // [RULE_07]
						else
							torque_cmd_gain <= pwdata[9:0];
					end
				end
				`REG_MAX_TORQUE:  max_torque <= pwdata[9:0];
				`REG_IRQ_ENABLE:  irq_enable <= pwdata[1:0];
				default:          ;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	// The converter word and host limit must be quasi-static across a loop tick.
	reg [11:0] code_meta;
	reg [11:0] code_sync;
	reg [12:0] host_meta;
	reg [12:0] host_sync;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			code_meta <= 12'h000;
			code_sync <= 12'h000;
			host_meta <= `SPEED_LIMIT_RESET;
			host_sync <= `SPEED_LIMIT_RESET;
		end
		else
		begin
			code_meta <= torque_cmd_code; // [RULE_11]
			code_sync <= code_meta;
			host_meta <= host_speed_limit;
			host_sync <= host_meta;
		end
	end

	// ------------------------------------------------------------------------
	// Speed limit
	// ------------------------------------------------------------------------
	// Internal value is not even read when the host source is chosen.
	wire [12:0]        active_limit = speed_limit_source_select ?
		host_sync : speed_limit_value; // [RULE_05] [RULE_06]
	wire signed [15:0] pos_limit    = {3'b000, active_limit};
	wire signed [15:0] neg_limit    = -pos_limit;
	wire               next_reached = abs16(motor_speed) >= {3'b000, active_limit};
	reg  signed [15:0] next_speed_ref;

	always @*
	begin
		if (speed_cmd > pos_limit)
			next_speed_ref = pos_limit; // [RULE_02]
		else if (speed_cmd < neg_limit)
			next_speed_ref = neg_limit; // [RULE_02]
		else
			next_speed_ref = speed_cmd;
	end

	// ------------------------------------------------------------------------
	// Torque loop
	// ------------------------------------------------------------------------
	reg  [15:0]        loop_count;
	reg                loop_tick;
	wire signed [11:0] scaled;
	wire               scaled_done;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			loop_count <= 16'h0000;
			loop_tick  <= 1'b0;
		end
		else
		begin
			loop_tick <= (loop_count == LOOP_CYCLES - 1); // [RULE_12]
			if (loop_count == LOOP_CYCLES - 1)
				loop_count <= 16'h0000;
			else
				loop_count <= loop_count + 16'h0001;
		end
	end

	torque_scaler u_scaler
	(
		.pclk    (pclk),
		.presetn (presetn),
		.start   (loop_tick),
		.sample  (code_sync), // [RULE_12]
		.gain    (torque_cmd_gain),
		.torque  (scaled),
		.done    (scaled_done)
	);

	wire [15:0] torque_mag = abs16({{4{scaled[11]}}, scaled});

	// ------------------------------------------------------------------------
	// Outputs and interrupt
	// ------------------------------------------------------------------------
	wire       next_warn   = scaled_done ? (torque_mag > {6'h00, max_torque}) :
		torque_cmd_overrange_warn; // [RULE_10]
	wire [1:0] events      = {next_warn & ~torque_cmd_overrange_warn,
		next_reached & ~speed_limit_reached};
	wire [1:0] clear_mask  = (wr_commit && paddr == `REG_IRQ_CLEAR) ? pwdata[1:0] : 2'h0;
	// A new event in the clearing cycle survives the clear.
	wire [1:0] next_status = (irq_status & ~clear_mask) | events;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			speed_ref                 <= 16'h0000;
			torque_ref                <= 12'h000;
			speed_limit_reached       <= 1'b0;
			torque_cmd_overrange_warn <= 1'b0;
			irq_status                <= 2'h0;
			irq                       <= 1'b0;
		end
		else
		begin
			speed_ref                 <= next_speed_ref; // [RULE_02]
			speed_limit_reached       <= next_reached; // [RULE_03]
			torque_cmd_overrange_warn <= next_warn;
			if (scaled_done)
				torque_ref <= scaled; // [RULE_07]
			irq_status <= next_status;
			irq        <= |(next_status & irq_enable);
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < OUT_CHANNELS; ch = ch + 1)
		begin : g_seq_out
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					seq_out[ch] <= 1'b0;
				else
					seq_out[ch] <= next_reached && (limit_channel == ch + 1); // [RULE_04]
			end
		end
	endgenerate
endmodule // speed_limit_torque_cmd_scaler

//--- verif/scaler_monitor.sv
`timescale 1ns/1ps
module scaler_monitor
#(
	parameter OUT_CHANNELS = 4,
	parameter LOOP_CYCLES  = 1000
)
(
	input wire                    pclk,
	input wire                    presetn,
	input wire                    psel,
	input wire                    penable,
	input wire                    pready,
	input wire                    pslverr,
	input wire signed [15:0]      speed_cmd,
	input wire signed [15:0]      motor_speed,
	input wire signed [15:0]      speed_ref,
	input wire signed [11:0]      torque_ref,
	input wire                    speed_limit_reached,
	input wire                    torque_cmd_overrange_warn,
	input wire [OUT_CHANNELS-1:0] seq_out
);
	wire [15:0] motor_abs  = motor_speed[15] ? -motor_speed : motor_speed;
	wire [15:0] speed_abs  = speed_ref[15] ? -speed_ref : speed_ref;
	wire [11:0] torque_abs = torque_ref[11] ? -torque_ref : torque_ref;
	logic signed [11:0] torque_last;
	int unsigned        torque_gap;

	// Counts the cycles since the torque reference last moved; a new value needs a full loop.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			torque_last <= 12'h000;
			torque_gap  <= 0;
		end
		else
		begin
			torque_last <= torque_ref;
			torque_gap  <= (torque_ref != torque_last) ? 0 : torque_gap + 1;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	speed_bound_a: assert property (speed_abs <= 16'h1388)
		else $error("speed reference above limit");
	speed_zero_a: assert property (speed_cmd == 16'h0000 |=> speed_ref == 16'h0000)
		else $error("zero command not passed");
	reached_top_a: assert property (motor_abs >= 16'h1388 |=> speed_limit_reached)
		else $error("reached flag missing");
	reached_low_a: assert property (motor_speed == 16'h0000 |=> !speed_limit_reached)
		else $error("reached flag at standstill");
	seq_gate_a: assert property ($onehot0(seq_out) && (seq_out == 0 || speed_limit_reached))
		else $error("sequence output not gated");
	torque_hold_a: assert property ($changed(torque_ref) |=> $stable(torque_ref)[*8])
		else $error("torque reference between ticks");
	tick_gap_a: assert property ($changed(torque_ref) |-> torque_gap >= LOOP_CYCLES - 1)
		else $error("torque reference moved inside a loop period");
	torque_bound_a: assert property (torque_abs <= 12'h3E8)
		else $error("torque reference above gain range");
	warn_cause_a: assert property (torque_cmd_overrange_warn |-> torque_ref != 0)
		else $error("warning without torque");
	slverr_pair_a: assert property (pslverr |-> pready && psel && penable)
		else $error("error response outside access");

	cover property (speed_limit_reached && seq_out != 0);
	cover property ($rose(torque_cmd_overrange_warn));
	cover property (pslverr);
endmodule // scaler_monitor

//--- verif/host_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Host controller: analog torque command and host speed limit
// ----------------------------------------------------------------------------
module host_ctrl_model
(
	input  wire logic signed [15:0] torque_req,
	input  wire logic        [12:0] limit_req,
	input  wire logic               pclk,
	output logic             [11:0] torque_cmd_code = 12'h000,
	output logic             [12:0] host_speed_limit = 13'h0000
);
	// A real host cannot swing past the supply, so torque requests are held in range.
	always @(posedge pclk)
	begin
		if (torque_req > 16'sh07FF)
			torque_cmd_code <= 12'h7FF;
		else if (torque_req < -16'sh0800)
			torque_cmd_code <= 12'h800;
		else
			torque_cmd_code <= torque_req[11:0];
		host_speed_limit <= limit_req;
	end
endmodule // host_ctrl_model

//--- verif/test_speed_limit_torque_cmd_scaler.sv
`timescale 1ns/1ps
module test_speed_limit_torque_cmd_scaler;
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
	logic        [7:0]  paddr;
	logic        [31:0] pwdata, prdata, rd;
	logic signed [15:0] speed_cmd, motor_speed, speed_ref, torque_req;
	logic        [12:0] host_speed_limit, limit_req;
	logic        [11:0] torque_cmd_code;
	logic signed [11:0] torque_ref;
	logic               speed_limit_reached, torque_cmd_overrange_warn;
	logic        [3:0]  seq_out;
	int                 miscompares, compares;

	speed_limit_torque_cmd_scaler #(.LOOP_CYCLES(10)) DUT (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .speed_cmd, .motor_speed,
		.host_speed_limit, .torque_cmd_code, .speed_ref, .torque_ref, .speed_limit_reached,
		.torque_cmd_overrange_warn, .seq_out, .irq);
	host_ctrl_model host (.pclk, .torque_req, .limit_req, .torque_cmd_code, .host_speed_limit);

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task close_out;
	begin
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
	begin
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
		end
	end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
	begin
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	end
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
	begin
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp, what);
	end
	endtask

	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{speed_cmd, motor_speed, limit_req, torque_req, miscompares, compares} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rchk(8'h04, 32'h0000_1388, "limit reset");
		rchk(8'h08, 32'h0000_014D, "gain reset");
		rchk(8'h0C, 32'h0000_012C, "max torque reset");
		apb(1'b1, 8'h04, 32'h0000_0000);
		rchk(8'h04, 32'h0000_0001, "limit floor");
		apb(1'b1, 8'h04, 32'h0000_03E8);
		apb(1'b1, 8'h00, 32'h0000_0008);
		speed_cmd   <= 16'sh05DC;
		motor_speed <= 16'sh03E8;
		repeat (4) @(posedge pclk);
		chk(speed_ref, 32'h0000_03E8, "clamp");
		chk(speed_limit_reached, 32'h0000_0001, "reached");
		chk(seq_out, 32'h0000_0002, "channel");
		speed_cmd <= -16'sh05DC;
		limit_req <= 13'h00C8;
		repeat (4) @(posedge pclk);
		chk(speed_ref, 32'hFFFF_FC18, "clamp neg");
		apb(1'b1, 8'h00, 32'h0000_000A);
		apb(1'b1, 8'h04, 32'h0000_0001);
		rchk(8'h00, 32'h0000_000A, "ctrl");
		repeat (4) @(posedge pclk);
		chk(speed_ref, 32'hFFFF_FF38, "host limit");
		motor_speed <= 16'sh0000;
		repeat (4) @(posedge pclk);
		chk(seq_out, 32'h0000_0000, "channel off");
		apb(1'b1, 8'h1C, 32'h0000_0002);
		torque_req <= 16'sh0266;
		repeat (30) @(posedge pclk);
		chk(torque_ref, 32'h0000_0063, "scale");
		chk(torque_cmd_overrange_warn, 32'h0000_0000, "no warn");
		torque_req <= 16'sh0FFF;
		repeat (30) @(posedge pclk);
		chk(torque_ref, 32'h0000_014C, "full scale");
		chk({torque_cmd_overrange_warn, irq}, 32'h0000_0003, "warn irq");
		rchk(8'h14, 32'h0000_0003, "status");
		apb(1'b1, 8'h18, 32'h0000_0003);
		torque_req <= -16'sh1000;
		repeat (30) @(posedge pclk);
		chk(irq, 32'h0000_0000, "irq clear");
		rchk(8'h14, 32'h0000_0000, "status clear");
		rchk(8'h20, 32'hFFFF_FEB3, "neg scale");
		rchk(8'h10, 32'h0000_0002, "state");
		apb(1'b1, 8'h00, 32'h0000_0001);
		apb(1'b1, 8'h08, 32'h0000_01F4);
		rchk(8'h08, 32'h0000_014D, "gain locked");
		apb(1'b1, 8'h00, 32'h0000_0000);
		apb(1'b1, 8'h08, 32'h0000_07D0);
		rchk(8'h08, 32'h0000_03E8, "gain sat");
		repeat (30) @(posedge pclk);
		chk(torque_ref, 32'hFFFF_FC18, "gain max");
		apb(1'b1, 8'h0C, 32'h0000_03E8);
		rchk(8'h0C, 32'h0000_03E8, "max torque");
		motor_speed <= 16'sh1388;
		repeat (30) @(posedge pclk);
		chk(torque_cmd_overrange_warn, 32'h0000_0000, "warn at max");
		chk(speed_limit_reached, 32'h0000_0001, "reached top");
		rchk(8'h24, 32'hFFFF_FFFF, "speed reg");
		rchk(8'h14, 32'h0000_0001, "status reached");
		rchk(8'h40, 32'h0000_0000, "unmapped");
		chk(err, 32'h0000_0001, "slverr");
		close_out;
	end

	initial
	begin
		repeat (5000) @(posedge pclk);
		miscompares++;
		close_out;
	end
endmodule // test_speed_limit_torque_cmd_scaler

bind speed_limit_torque_cmd_scaler scaler_monitor #(.OUT_CHANNELS(OUT_CHANNELS),
	.LOOP_CYCLES(LOOP_CYCLES)) mon (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
	.speed_cmd, .motor_speed, .speed_ref, .torque_ref, .speed_limit_reached,
	.torque_cmd_overrange_warn, .seq_out);
